// ==== logic/radb_pkg.sv ====
/*
 * Package of the addressing parameter store: command codes, carriers,
 * reset values, field positions, ranges and timing counts.
 * Assumes a host-side parser that turns serial parameter commands into
 * one command word per request.
 */
package radb_pkg;

   typedef enum logic [3:0] {
      RADB_P_SERIAL_HIGH,
      RADB_P_SERIAL_LOW,
      RADB_P_DEST_HIGH,
      RADB_P_DEST_LOW,
      RADB_P_TX_OPTIONS,
      RADB_P_NODE_NAME,
      RADB_P_BACKOFF,
      RADB_P_DISC_OPTIONS,
      RADB_P_CLUSTER,
      RADB_P_DISC_TIMEOUT,
      RADB_P_REGION,
      RADB_P_COLLECTOR
   } radb_param_t;

   typedef struct packed {
      radb_param_t param;
      logic write;
      logic [63:0] data;
   } radb_cmd_t;

   typedef struct packed {
      logic ok;
      logic [63:0] data;
   } radb_rsp_t;

   localparam logic [31:0] RADB_DEST_HIGH_RST = 32'h0000_0000;
   localparam logic [31:0] RADB_DEST_LOW_RST = 32'h0000_FFFF;
   localparam logic [31:0] RADB_ADDR_HALF_MAX = 32'h0FFF_FFFF;
   localparam logic [63:0] RADB_BROADCAST = 64'h0000_0000_0000_FFFF;
   localparam logic [31:0] RADB_SHORT_LIMIT = 32'h0000_FFFF;

   localparam logic [7:0] RADB_TXOPT_RST_SLOW = 8'h40;
   localparam logic [7:0] RADB_TXOPT_RST_FAST = 8'hC0;
   localparam int RADB_DELIV_LSB = 6;
   localparam logic [1:0] RADB_DELIV_INVALID = 2'h0;
   localparam logic [1:0] RADB_DELIV_P2MP = 2'h1;
   localparam logic [1:0] RADB_DELIV_REPEATER = 2'h2;
   localparam logic [1:0] RADB_DELIV_MESH = 2'h3;

   localparam int RADB_NAME_MAX = 20;
   localparam logic [7:0] RADB_NAME_RST_CHAR = 8'h20;
   localparam logic [7:0] RADB_CHAR_CR = 8'h0D;
   localparam logic [7:0] RADB_CHAR_COMMA = 8'h2C;
   localparam logic [7:0] RADB_CHAR_LOW = 8'h20;
   localparam logic [7:0] RADB_CHAR_HIGH = 8'h7E;

   localparam logic [15:0] RADB_BACKOFF_RST = 16'h0082;
   localparam logic [15:0] RADB_BACKOFF_MIN = 16'h0020;
   localparam logic [15:0] RADB_BACKOFF_MAX = 16'h2EE0;
   localparam int RADB_BACKOFF_UNIT_MS = 100;

   localparam logic [7:0] RADB_DOPT_RST = 8'h00;
   localparam logic [7:0] RADB_DOPT_MAX = 8'h07;
   localparam int RADB_DOPT_TYPE_BIT = 0;
   localparam int RADB_DOPT_SELF_BIT = 1;
   localparam int RADB_DOPT_RSSI_BIT = 2;

   localparam logic [15:0] RADB_CLU_TRANSPARENT = 16'h0011;
   localparam logic [15:0] RADB_CLU_LOOPBACK = 16'h0012;
   localparam logic [15:0] RADB_CLU_LINK_REQ = 16'h0014;
   localparam logic [15:0] RADB_CLU_LINK_RES = 16'h0094;
   localparam logic [15:0] RADB_CLU_MEMORY = 16'h0023;

   localparam logic [7:0] RADB_REGION_USA = 8'h01;
   localparam logic [7:0] RADB_REGION_AUS = 8'h02;
   localparam logic [7:0] RADB_REGION_BRA = 8'h03;
   localparam logic [7:0] RADB_REGION_NZL = 8'h06;

   localparam logic [7:0] RADB_FRAME_ADDR_UPDATE = 8'h8E;

endpackage

// ==== logic/radb_param_bank.sv ====
/*
 * Addressing parameter store of the radio module: factory source address,
 * destination address, delivery options, node name, discovery settings,
 * cluster tag, timeout and region, plus collector broadcast handling.
 * Assumes one clock; commands, name characters and radio events come from
 * logic on the same clock, so no input is synchronised here.
 */
`timescale 1ns/1ps

module radb_param_bank #(
   parameter logic [63:0] FACTORY_ADDR = 64'h0123_4567_89AB_CDEF, // Arbitrary value.
   parameter logic [7:0] REGION = 8'h01,
   parameter logic [31:0] PROPAGATION_MS = 32'h0000_0064
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire radb_pkg::radb_cmd_t cmd,
   output logic cmd_ready,
   output logic rsp_valid,
   output radb_pkg::radb_rsp_t rsp,
   input wire logic name_char_valid,
   input wire logic [7:0] name_char,
   output logic [159:0] node_name,
   output logic [4:0] node_name_len,
   input wire logic rf_rate_select,
   input wire logic tx_req,
   input wire logic frame_flags_valid,
   input wire logic [7:0] frame_send_flags,
   output logic tx_go,
   output logic tx_invalid,
   output logic [1:0] tx_delivery,
   output logic [63:0] tx_dest,
   output logic tx_short,
   output logic tx_broadcast,
   output logic [15:0] tx_cluster,
   output logic [63:0] dest_addr,
   output logic [15:0] backoff_limit,
   output logic disc_append_type,
   output logic disc_self_response,
   output logic disc_append_rssi,
   input wire logic rx_valid,
   input wire logic [15:0] rx_cluster,
   output logic rx_loopback,
   output logic rx_cluster_known,
   input wire logic lookup_done,
   input wire logic command_mode,
   input wire logic [63:0] lookup_addr,
   input wire logic collector_valid,
   input wire logic [63:0] collector_param,
   input wire logic [63:0] collector_origin,
   input wire logic route_space,
   input wire logic api_mode,
   output logic route_add,
   output logic [63:0] route_addr,
   output logic update_frame_valid,
   output logic [7:0] update_frame_type,
   output logic collector_send,
   output logic [63:0] collector_send_param
);
   import radb_pkg::*;

   typedef enum logic {RADB_IDLE, RADB_NAME} radb_state_t;

   function automatic logic radb_printable(input logic [7:0] c);
      radb_printable = (c >= RADB_CHAR_LOW) && (c <= RADB_CHAR_HIGH);
   endfunction

   function automatic logic radb_known_cluster(input logic [15:0] id);
      radb_known_cluster = (id == RADB_CLU_TRANSPARENT) || (id == RADB_CLU_LOOPBACK) ||
         (id == RADB_CLU_LINK_REQ) || (id == RADB_CLU_LINK_RES) || (id == RADB_CLU_MEMORY);
   endfunction

   radb_state_t state_r, state_nxt;
   logic [31:0] dest_high_r, dest_high_nxt;
   logic [31:0] dest_low_r, dest_low_nxt;
   logic [7:0] tx_opt_r, tx_opt_nxt;
   logic opt_loaded_r;
   logic [159:0] name_r, name_nxt;
   logic [4:0] name_len_r, name_len_nxt;
   logic [159:0] shadow_r, shadow_nxt;
   logic [5:0] shadow_len_r, shadow_len_nxt;
   logic shadow_bad_r, shadow_bad_nxt;
   logic [15:0] backoff_r, backoff_nxt;
   logic [7:0] dopt_r, dopt_nxt;
   logic [15:0] cluster_r, cluster_nxt;
   logic [31:0] timeout_r;
   logic rsp_valid_nxt;
   radb_rsp_t rsp_nxt;

   wire cmd_take = cmd_valid && (state_r == RADB_IDLE);
   wire cmd_wr = cmd_take && cmd.write;
   wire [31:0] wdata_lo = cmd.data[31:0];
   wire char_take = name_char_valid && (state_r == RADB_NAME);
   wire char_end = (name_char == RADB_CHAR_CR) || (name_char == RADB_CHAR_COMMA);
   wire [63:0] dest_now = {dest_high_r, dest_low_r};
   wire coll_match = collector_valid && (collector_param == dest_now);
   wire lookup_load = lookup_done && command_mode;
   wire host_dest_wr = cmd_wr && ((cmd.param == RADB_P_DEST_HIGH) ||
                                  (cmd.param == RADB_P_DEST_LOW));
   wire [7:0] opt_eff = frame_flags_valid ? frame_send_flags : tx_opt_r;
   wire [1:0] deliv_raw = opt_eff[RADB_DELIV_LSB +: 2];
   wire [1:0] deliv_eff = (!rf_rate_select && deliv_raw != RADB_DELIV_INVALID) ?
                          RADB_DELIV_P2MP : deliv_raw;
   wire [63:0] dest_next_w = {dest_high_nxt, dest_low_nxt};
   wire [31:0] backoff_ms = 32'(backoff_nxt) * 32'(RADB_BACKOFF_UNIT_MS);

   // Write decoding and range checks for host commands.
   always_comb begin
      state_nxt = state_r;
      dest_high_nxt = dest_high_r;
      dest_low_nxt = dest_low_r;
      tx_opt_nxt = tx_opt_r;
      name_nxt = name_r;
      name_len_nxt = name_len_r;
      shadow_nxt = shadow_r;
      shadow_len_nxt = shadow_len_r;
      shadow_bad_nxt = shadow_bad_r;
      backoff_nxt = backoff_r;
      dopt_nxt = dopt_r;
      cluster_nxt = cluster_r;
      rsp_valid_nxt = 1'b0;
      rsp_nxt = '0;
      if (!opt_loaded_r) begin
         tx_opt_nxt = rf_rate_select ? RADB_TXOPT_RST_FAST : RADB_TXOPT_RST_SLOW;
      end
      if (cmd_take) begin
         rsp_valid_nxt = 1'b1;
         rsp_nxt.ok = 1'b1;
         unique case (cmd.param)
            RADB_P_SERIAL_HIGH: begin
               rsp_nxt.data = {32'h0, FACTORY_ADDR[63:32]};
               rsp_nxt.ok = !cmd.write;
            end
            RADB_P_SERIAL_LOW: begin
               rsp_nxt.data = {32'h0, FACTORY_ADDR[31:0]};
               rsp_nxt.ok = !cmd.write;
            end
            RADB_P_DEST_HIGH: begin
               rsp_nxt.data = {32'h0, dest_high_r};
               if (cmd.write) begin
                  rsp_nxt.ok = (cmd.data[63:32] == 32'h0) && (wdata_lo <= RADB_ADDR_HALF_MAX);
                  if (rsp_nxt.ok) begin
                     dest_high_nxt = wdata_lo;
                  end
               end
            end
            RADB_P_DEST_LOW: begin
               rsp_nxt.data = {32'h0, dest_low_r};
               if (cmd.write) begin
                  rsp_nxt.ok = (cmd.data[63:32] == 32'h0) && (wdata_lo <= RADB_ADDR_HALF_MAX);
                  if (rsp_nxt.ok) begin
                     dest_low_nxt = wdata_lo;
                  end
               end
            end
            RADB_P_TX_OPTIONS: begin
               rsp_nxt.data = {56'h0, tx_opt_r};
               if (cmd.write) begin
                  rsp_nxt.ok = (cmd.data[63:8] == 56'h0);
                  if (rsp_nxt.ok) begin
                     tx_opt_nxt = cmd.data[7:0];
                  end
               end
            end
            RADB_P_NODE_NAME: begin
               rsp_nxt.data = {59'h0, name_len_r};
               if (cmd.write) begin
                  // The answer waits for the terminating character.
                  rsp_valid_nxt = 1'b0;
                  state_nxt = RADB_NAME;
                  shadow_nxt = '0;
                  shadow_len_nxt = '0;
                  shadow_bad_nxt = 1'b0;
               end
            end
            RADB_P_BACKOFF: begin
               rsp_nxt.data = {48'h0, backoff_r};
               if (cmd.write) begin
                  rsp_nxt.ok = (cmd.data[63:16] == 48'h0) &&
                     (cmd.data[15:0] >= RADB_BACKOFF_MIN) &&
                     (cmd.data[15:0] <= RADB_BACKOFF_MAX);
                  if (rsp_nxt.ok) begin
                     backoff_nxt = cmd.data[15:0];
                  end
               end
            end
            RADB_P_DISC_OPTIONS: begin
               rsp_nxt.data = {56'h0, dopt_r};
               if (cmd.write) begin
                  rsp_nxt.ok = (cmd.data[63:8] == 56'h0) &&
                     (cmd.data[7:0] <= RADB_DOPT_MAX);
                  if (rsp_nxt.ok) begin
                     dopt_nxt = cmd.data[7:0];
                  end
               end
            end
            RADB_P_CLUSTER: begin
               rsp_nxt.data = {48'h0, cluster_r};
               if (cmd.write) begin
                  rsp_nxt.ok = (cmd.data[63:16] == 48'h0);
                  if (rsp_nxt.ok) begin
                     cluster_nxt = cmd.data[15:0];
                  end
               end
            end
            RADB_P_DISC_TIMEOUT: begin
               rsp_nxt.data = {32'h0, timeout_r};
               rsp_nxt.ok = !cmd.write;
            end
            RADB_P_REGION: begin
               rsp_nxt.data = {56'h0, REGION};
               rsp_nxt.ok = !cmd.write;
            end
            RADB_P_COLLECTOR: begin
               rsp_nxt.ok = cmd.write;
            end
            default: begin
               rsp_nxt.ok = 1'b0;
            end
         endcase
      end
      if (char_take) begin
         if (char_end) begin
            state_nxt = RADB_IDLE;
            rsp_valid_nxt = 1'b1;
            rsp_nxt.ok = !shadow_bad_r && (shadow_len_r <= 6'(RADB_NAME_MAX));
            rsp_nxt.data = {58'h0, shadow_len_r};
            if (rsp_nxt.ok) begin
               name_nxt = shadow_r;
               name_len_nxt = shadow_len_r[4:0];
            end
         end else begin
            if (!radb_printable(name_char)) begin
               shadow_bad_nxt = 1'b1;
            end
            if (shadow_len_r < 6'(RADB_NAME_MAX)) begin
               shadow_nxt[8 * shadow_len_r[4:0] +: 8] = name_char;
            end
            // Counting saturates so an overlong string cannot wrap into a legal length.
            if (shadow_len_r <= 6'(RADB_NAME_MAX)) begin
               shadow_len_nxt = shadow_len_r + 6'h01;
            end
         end
      end
      // Host writes take priority; a lookup result outranks a collector update.
      if (!host_dest_wr) begin
         if (lookup_load) begin
            dest_high_nxt = lookup_addr[63:32];
            dest_low_nxt = lookup_addr[31:0];
         end else if (coll_match) begin
            dest_high_nxt = collector_origin[63:32];
            dest_low_nxt = collector_origin[31:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= RADB_IDLE;
         dest_high_r <= RADB_DEST_HIGH_RST;
         dest_low_r <= RADB_DEST_LOW_RST;
         tx_opt_r <= RADB_TXOPT_RST_SLOW;
         opt_loaded_r <= 1'b0;
         name_r <= {152'h0, RADB_NAME_RST_CHAR};
         name_len_r <= 5'h01;
         shadow_r <= '0;
         shadow_len_r <= '0;
         shadow_bad_r <= 1'b0;
         backoff_r <= RADB_BACKOFF_RST;
         dopt_r <= RADB_DOPT_RST;
         cluster_r <= RADB_CLU_TRANSPARENT;
      end else begin
         state_r <= state_nxt;
         dest_high_r <= dest_high_nxt;
         dest_low_r <= dest_low_nxt;
         tx_opt_r <= tx_opt_nxt;
         opt_loaded_r <= 1'b1;
         name_r <= name_nxt;
         name_len_r <= name_len_nxt;
         shadow_r <= shadow_nxt;
         shadow_len_r <= shadow_len_nxt;
         shadow_bad_r <= shadow_bad_nxt;
         backoff_r <= backoff_nxt;
         dopt_r <= dopt_nxt;
         cluster_r <= cluster_nxt;
      end
   end

   // Registered outputs and answers.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp <= '0;
         node_name <= {152'h0, RADB_NAME_RST_CHAR};
         node_name_len <= 5'h01;
         dest_addr <= {RADB_DEST_HIGH_RST, RADB_DEST_LOW_RST};
         backoff_limit <= RADB_BACKOFF_RST;
         timeout_r <= '0;
         disc_append_type <= 1'b0;
         disc_self_response <= 1'b0;
         disc_append_rssi <= 1'b0;
      end else begin
         cmd_ready <= (state_nxt == RADB_IDLE);
         rsp_valid <= rsp_valid_nxt;
         rsp <= rsp_nxt;
         node_name <= name_nxt;
         node_name_len <= name_len_nxt;
         dest_addr <= dest_next_w;
         backoff_limit <= backoff_nxt;
         timeout_r <= backoff_ms + PROPAGATION_MS;
         disc_append_type <= dopt_nxt[RADB_DOPT_TYPE_BIT];
         disc_self_response <= dopt_nxt[RADB_DOPT_SELF_BIT];
         disc_append_rssi <= dopt_nxt[RADB_DOPT_RSSI_BIT];
      end
   end

   // Transmit descriptor, sampled per request so frame flags affect one frame only.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_go <= 1'b0;
         tx_invalid <= 1'b0;
         tx_delivery <= RADB_DELIV_INVALID;
         tx_dest <= '0;
         tx_short <= 1'b0;
         tx_broadcast <= 1'b0;
         tx_cluster <= '0;
      end else begin
         tx_go <= tx_req && (deliv_eff != RADB_DELIV_INVALID);
         tx_invalid <= tx_req && (deliv_eff == RADB_DELIV_INVALID);
         if (tx_req) begin
            tx_delivery <= deliv_eff;
            tx_dest <= dest_now;
            tx_short <= (dest_high_r == 32'h0) && (dest_low_r < RADB_SHORT_LIMIT);
            tx_broadcast <= (dest_now == RADB_BROADCAST);
            tx_cluster <= cluster_r;
         end
      end
   end

   // Receive-side cluster handling and collector broadcast effects.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rx_loopback <= 1'b0;
         rx_cluster_known <= 1'b0;
         route_add <= 1'b0;
         route_addr <= '0;
         update_frame_valid <= 1'b0;
         update_frame_type <= RADB_FRAME_ADDR_UPDATE;
         collector_send <= 1'b0;
         collector_send_param <= '0;
      end else begin
         rx_loopback <= rx_valid && (rx_cluster == RADB_CLU_LOOPBACK);
         rx_cluster_known <= rx_valid && radb_known_cluster(rx_cluster);
         route_add <= collector_valid && route_space;
         if (collector_valid) begin
            route_addr <= collector_origin;
         end
         // A host destination write in the same cycle wins, so no update frame is sent then.
         update_frame_valid <= coll_match && !lookup_load && !host_dest_wr && api_mode;
         update_frame_type <= RADB_FRAME_ADDR_UPDATE;
         collector_send <= cmd_wr && (cmd.param == RADB_P_COLLECTOR);
         if (cmd_wr && (cmd.param == RADB_P_COLLECTOR)) begin
            collector_send_param <= cmd.data;
         end
      end
   end

endmodule

// ==== tb/radb_param_bank_assertions.sv ====
/*
 * Concurrent checks on the ports of the addressing parameter store.
 * Assumes one clock, an active-low reset, and a bind onto the store.
 */
`timescale 1ns/1ps

module radb_param_bank_assertions #(
   parameter logic [63:0] FACTORY_ADDR = 64'h0
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire radb_pkg::radb_cmd_t cmd,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire radb_pkg::radb_rsp_t rsp,
   input wire logic rf_rate_select,
   input wire logic tx_req,
   input wire logic tx_go,
   input wire logic tx_invalid,
   input wire logic [1:0] tx_delivery,
   input wire logic [63:0] tx_dest,
   input wire logic tx_short,
   input wire logic tx_broadcast,
   input wire logic rx_valid,
   input wire logic [15:0] rx_cluster,
   input wire logic rx_loopback,
   input wire logic collector_valid,
   input wire logic [63:0] collector_origin,
   input wire logic route_space,
   input wire logic route_add,
   input wire logic [63:0] route_addr,
   input wire logic update_frame_valid
);
   import radb_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire take = cmd_valid && cmd_ready;
   wire src_param = cmd.param == RADB_P_SERIAL_HIGH || cmd.param == RADB_P_SERIAL_LOW;
   sequence s_read(radb_param_t p);
      take && !cmd.write && cmd.param == p;
   endsequence
   sequence s_tx_slow;
      tx_req && !rf_rate_select;
   endsequence
   property p_src_high;
      s_read(RADB_P_SERIAL_HIGH) |=> rsp_valid && rsp.data[31:0] == FACTORY_ADDR[63:32];
   endproperty
   a_src_high: assert property (p_src_high) else $error("source high wrong");
   property p_src_low;
      s_read(RADB_P_SERIAL_LOW) |=> rsp_valid && rsp.data[31:0] == FACTORY_ADDR[31:0];
   endproperty
   a_src_low: assert property (p_src_low) else $error("source low wrong");
   property p_src_ro;
      take && cmd.write && src_param |=> rsp_valid && !rsp.ok;
   endproperty
   a_src_ro: assert property (p_src_ro) else $error("source write taken");
   property p_short;
      tx_go |-> tx_short == (tx_dest[63:32] == 32'h0 && tx_dest[31:0] < RADB_SHORT_LIMIT);
   endproperty
   a_short: assert property (p_short) else $error("short flag wrong");
   property p_bcast;
      tx_go |-> tx_broadcast == (tx_dest == RADB_BROADCAST);
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");
   property p_one_answer;
      tx_req |=> tx_go ^ tx_invalid;
   endproperty
   a_one_answer: assert property (p_one_answer) else $error("transmit answer wrong");
   property p_slow_p2mp;
      s_tx_slow |=> tx_invalid || tx_delivery == RADB_DELIV_P2MP;
   endproperty
   a_slow_p2mp: assert property (p_slow_p2mp) else $error("slow rate not p2mp");
   property p_loop;
      rx_valid |=> rx_loopback == ($past(rx_cluster) == RADB_CLU_LOOPBACK);
   endproperty
   a_loop: assert property (p_loop) else $error("loopback flag wrong");
   property p_route;
      collector_valid && route_space |=> route_add && route_addr == $past(collector_origin);
   endproperty
   a_route: assert property (p_route) else $error("route not added");
   property p_frame;
      update_frame_valid |-> $past(collector_valid);
   endproperty
   a_frame: assert property (p_frame) else $error("update frame without cause");
endmodule

bind radb_param_bank radb_param_bank_assertions #(.FACTORY_ADDR(FACTORY_ADDR)) u_chk (.*);

// ==== tb/radb_host_model.sv ====
/*
 * Host that issues parameter commands and streams name characters.
 * Assumes calls start just after a falling clock edge.
 */
`timescale 1ns/1ps

module radb_host_model (
   input wire logic clk_sys,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire radb_pkg::radb_rsp_t rsp,
   output radb_pkg::radb_cmd_t cmd,
   output logic cmd_valid,
   output logic name_char_valid,
   output logic [7:0] name_char
);
   import radb_pkg::*;
   initial begin
      cmd = '0;
      cmd_valid = 1'b0;
      name_char_valid = 1'b0;
      name_char = 8'h00;
   end
   task automatic access(input radb_param_t p, input logic w, input logic [63:0] d,
                         input byte txt[$], output logic ok, output logic [63:0] q);
      int n;
      // A spare edge keeps a new request off the edge where the last one was released.
      @(negedge clk_sys);
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      cmd_valid = 1'b1;
      cmd = '{param: p, write: w, data: d};
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      // Released data is inverted so a stale value cannot be mistaken for a live one.
      cmd.data = ~d;
      foreach (txt[i]) begin
         name_char_valid = 1'b1;
         name_char = txt[i];
         @(negedge clk_sys);
      end
      name_char_valid = 1'b0;
      name_char = ~name_char;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 8) begin
         @(negedge clk_sys);
         n++;
      end
      ok = (rsp_valid === 1'b1) ? rsp.ok : 1'bx;
      q = rsp.data;
   endtask
endmodule

// ==== tb/test_radb_param_bank.sv ====
/*
 * Self-checking bench of the addressing parameter store.
 * Assumes the host model owns the command side; the bench drives the rest.
 */
`timescale 1ns/1ps

module test_radb_param_bank;
   import radb_pkg::*;
   localparam logic [63:0] FACT = 64'h1122_3344_5566_7788; // Arbitrary value.
   radb_cmd_t cmd;
   radb_rsp_t rsp;
   logic clk_sys, resetn, cmd_valid, cmd_ready, rsp_valid, name_char_valid, rf_rate_select;
   logic tx_req, frame_flags_valid, tx_go, tx_invalid, tx_short, tx_broadcast, rx_valid;
   logic rx_loopback, rx_cluster_known, lookup_done, command_mode, collector_valid, ok;
   logic route_space, api_mode, route_add, update_frame_valid, collector_send;
   logic disc_append_type, disc_self_response, disc_append_rssi;
   logic [7:0] name_char, frame_send_flags, update_frame_type;
   logic [1:0] tx_delivery;
   logic [4:0] node_name_len;
   logic [15:0] tx_cluster, backoff_limit, rx_cluster;
   logic [159:0] node_name;
   logic [63:0] tx_dest, dest_addr, lookup_addr, collector_param, collector_origin, q;
   logic [63:0] route_addr, collector_send_param;
   logic [15:0] clu [6] = '{16'h0011, 16'h0012, 16'h0014, 16'h0094, 16'h0023, 16'h0015};
   byte none[$];
   int error_cnt = 0;
   int cmp_count = 0;

   radb_param_bank #(.FACTORY_ADDR(FACT)) u_radb_param_bank (.*);

   radb_host_model u_radb_host_model (
      .clk_sys(clk_sys), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .cmd(cmd), .cmd_valid(cmd_valid), .name_char_valid(name_char_valid),
      .name_char(name_char));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [71:0] g, input logic [71:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic rd(input radb_param_t p, input logic [63:0] e);
      u_radb_host_model.access(p, 1'b0, 64'h0, none, ok, q);
      chk({ok, q}, {1'b1, e});
   endtask

   task automatic wr(input radb_param_t p, input logic [63:0] d, input logic e);
      u_radb_host_model.access(p, 1'b1, d, none, ok, q);
      chk(ok, e);
   endtask

   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask

   task automatic t_defaults();
      rd(RADB_P_DEST_HIGH, 64'h0);
      rd(RADB_P_DEST_LOW, 64'hFFFF);
      rd(RADB_P_TX_OPTIONS, 64'h40);
      rd(RADB_P_BACKOFF, 64'h82);
      rd(RADB_P_DISC_OPTIONS, 64'h0);
      rd(RADB_P_CLUSTER, 64'h11);
      rd(RADB_P_REGION, 64'h1);
      rd(RADB_P_DISC_TIMEOUT, 64'h332C);
      rd(RADB_P_SERIAL_HIGH, {32'h0, FACT[63:32]});
      wr(RADB_P_SERIAL_LOW, 64'h0, 1'b0);
      wr(RADB_P_REGION, 64'h2, 1'b0);
      rd(RADB_P_SERIAL_LOW, {32'h0, FACT[31:0]});
   endtask

   task automatic t_tx();
      wr(RADB_P_DEST_LOW, 64'h1234, 1'b1);
      pulse(tx_req);
      chk({tx_short, tx_broadcast, tx_dest}, {2'h2, 64'h1234});
      wr(RADB_P_DEST_LOW, 64'hFFFF, 1'b1);
      pulse(tx_req);
      chk({tx_short, tx_broadcast, tx_dest}, {2'h1, 64'hFFFF});
      wr(RADB_P_DEST_HIGH, 64'h1000_0000, 1'b0);
      wr(RADB_P_DEST_HIGH, 64'h0FFF_FFFF, 1'b1);
      chk(dest_addr, 64'h0FFF_FFFF_0000_FFFF);
      for (int r = 0; r < 2; r++) begin
         rf_rate_select = r[0];
         for (int m = 0; m < 4; m++) begin
            wr(RADB_P_TX_OPTIONS, {56'h0, m[1:0], 6'h0}, 1'b1);
            pulse(tx_req);
            chk({tx_invalid, tx_go}, {m == 0, m != 0});
            if (m != 0) chk(tx_delivery, (r == 0) ? RADB_DELIV_P2MP : m[1:0]);
         end
      end
      frame_send_flags = 8'h80;
      frame_flags_valid = 1'b1;
      pulse(tx_req);
      frame_flags_valid = 1'b0;
      chk(tx_delivery, RADB_DELIV_REPEATER);
   endtask

   task automatic t_name();
      byte s[$];
      s = '{8'h41, 8'h62, 8'h2C};
      u_radb_host_model.access(RADB_P_NODE_NAME, 1'b1, 64'h0, s, ok, q);
      chk({ok, q}, {1'b1, 64'h2});
      chk({node_name_len, node_name[15:0]}, {5'h02, 16'h6241});
      s = {};
      repeat (21) s.push_back(8'h7A);
      s.push_back(8'h0D);
      u_radb_host_model.access(RADB_P_NODE_NAME, 1'b1, 64'h0, s, ok, q);
      chk({ok, node_name_len}, {1'b0, 5'h02});
   endtask

   task automatic t_disc();
      wr(RADB_P_BACKOFF, 64'h1F, 1'b0);
      wr(RADB_P_BACKOFF, 64'h2EE1, 1'b0);
      wr(RADB_P_BACKOFF, 64'h2EE0, 1'b1);
      @(negedge clk_sys);
      rd(RADB_P_DISC_TIMEOUT, 64'h0012_4FE4);
      chk(backoff_limit, 16'h2EE0);
      wr(RADB_P_DISC_OPTIONS, 64'h8, 1'b0);
      for (int b = 0; b < 3; b++) begin
         wr(RADB_P_DISC_OPTIONS, 64'h1 << b, 1'b1);
         chk({disc_append_rssi, disc_self_response, disc_append_type}, 3'h1 << b);
      end
   endtask

   task automatic t_cluster();
      wr(RADB_P_CLUSTER, 64'h12, 1'b1);
      pulse(tx_req);
      chk(tx_cluster, 16'h0012);
      wr(RADB_P_CLUSTER, 64'h1_0000, 1'b0);
      foreach (clu[i]) begin
         rx_cluster = clu[i];
         pulse(rx_valid);
         chk({rx_loopback, rx_cluster_known}, {clu[i] == 16'h0012, i < 5});
      end
   endtask

   task automatic t_collector();
      wr(RADB_P_DEST_HIGH, 64'h0, 1'b1);
      wr(RADB_P_DEST_LOW, 64'h1234, 1'b1);
      wr(RADB_P_COLLECTOR, 64'h1234, 1'b1);
      chk({collector_send, collector_send_param}, {1'b1, 64'h1234});
      {api_mode, route_space} = 2'h3;
      collector_origin = 64'h0ABC;
      collector_param = 64'h5555;
      pulse(collector_valid);
      chk({route_add, update_frame_valid, route_addr}, {2'h2, 64'h0ABC});
      chk(dest_addr, 64'h1234);
      collector_param = 64'h1234;
      route_space = 1'b0;
      pulse(collector_valid);
      chk({route_add, update_frame_valid, update_frame_type}, {2'h1, 8'h8E});
      chk(dest_addr, 64'h0ABC);
      lookup_addr = 64'h0777;
      pulse(lookup_done);
      chk(dest_addr, 64'h0ABC);
      command_mode = 1'b1;
      pulse(lookup_done);
      chk(dest_addr, 64'h0777);
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      {resetn, rf_rate_select, tx_req, frame_flags_valid, rx_valid, lookup_done} = '0;
      {command_mode, collector_valid, route_space, api_mode} = '0;
      {frame_send_flags, rx_cluster, lookup_addr, collector_param, collector_origin} = '0;
      repeat (4) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (2) @(negedge clk_sys);
      t_defaults();
      t_tx();
      t_name();
      t_disc();
      t_cluster();
      t_collector();
      tally_and_finish();
   end

   // Far beyond the expected run length, so this trips only on a hang.
   initial begin
      #40000;
      error_cnt++;
      tally_and_finish();
   end
endmodule
